// ---- rtl/tcp_pkg.sv ----
/*
 Package of the 16-bit capture / pulse timer: register offsets, field
 positions, codes and the carried state of the block.
 Assumes an AXI4-Lite bus with 32-bit data and byte addresses.
*/
package tcp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_RUN = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_FFCR = 8'h08;
    localparam logic [7:0] OFS_IRQEN = 8'h0c;
    localparam logic [7:0] OFS_CMP0 = 8'h10;
    localparam logic [7:0] OFS_CMP1 = 8'h14;
    localparam logic [7:0] OFS_CAP0 = 8'h18;
    localparam logic [7:0] OFS_CAP1 = 8'h1c;
    localparam logic [7:0] OFS_COUNT = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_MASK = 8'h28;
    // Run register bits
    localparam int RUN_CNT = 0;
    localparam int RUN_PRE = 2;
    localparam int RUN_DBUF = 7;
    // Mode register fields
    localparam int MODE_CLR = 5;
    localparam int MODE_SWCAP = 6;
    localparam int MODE_CPM_LO = 3;
    localparam logic [1:0] CLK_EXT = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV8 = 2'h2;
    localparam logic [1:0] CPM_OFF = 2'h0;
    localparam logic [1:0] CPM_RISE_FALL = 2'h2;
    // Prescaler tap masks for the three internal clocks
    localparam logic [7:0] PRE_MASK2 = 8'h01;
    localparam logic [7:0] PRE_MASK8 = 8'h07;
    localparam logic [7:0] PRE_MASK32 = 8'h1f;
    // Flip-flop control bits
    localparam int FF_CLEAR = 0;
    localparam int FF_POL = 1;
    localparam int FF_T0 = 2;
    localparam int FF_T1 = 3;
    localparam int FF_TCAP = 4;
    // Interrupt enable priority fields
    localparam int IE_C0_LO = 0;
    localparam int IE_C1_LO = 4;
    // Status bits
    localparam int ST_C0 = 0;
    localparam int ST_C1 = 1;
    localparam int ST_TRIG = 2;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Carried state of the whole block
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] run;
        logic [7:0] mode;
        logic [7:0] ffcr;
        logic [7:0] irqen;
        logic [15:0] cmp0;
        logic [15:0] cmp0_buf;
        logic [15:0] cmp1;
        logic [15:0] cap0;
        logic [15:0] cap1;
        logic [15:0] count;
        logic [7:0] pre;
        logic trig_prev;
        logic toggle_ff;
        logic pin;
        logic [2:0] status;
        logic [2:0] mask;
        logic irq;
        logic c0_irq;
        logic c1_irq;
        logic trig_irq;
    } tcp_state_t;
endpackage

// ---- rtl/tcp_timer16.sv ----
/*
 16-bit timer / event counter with two compares, two captures, a toggle
 flip-flop driving the pulse pin, and an AXI4-Lite register slave.
 Assumes pins already synchronous to aclk and one AXI master.
*/
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tcp_timer16 (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trigger_count_input,
    output logic pulse_output_pin,
    output logic compare0_irq,
    output logic compare1_irq,
    output logic trigger_ext_irq,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte-lane merge of a write into an old register value
    function automatic logic [31:0] tcp_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Address decode shared by read and write sides
    function automatic logic tcp_mapped(input logic [7:0] a);
        return (a <= tcp_pkg::OFS_MASK) && (a[1:0] == 2'h0);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    tcp_pkg::tcp_state_t s; // Registered state
    tcp_pkg::tcp_state_t next_s; // Next state
    logic [31:0] wv; // Merged write value
    logic do_wr; // Write commits this cycle
    logic tick; // Prescaler clock tick
    logic cnt_en; // Counter advances
    logic [15:0] cnt_nx; // Counter after advance
    logic m0; // Compare-0 match event
    logic m1; // Compare-1 match event
    logic rise; // Trigger rising edge
    logic fall; // Trigger falling edge
    logic cap0_ld; // Capture 0 loads
    logic trig_ev; // Trigger interrupt event
    logic [2:0] ev; // Status set events
    logic [7:0] pmask; // Selected prescaler tap
    logic [31:0] rd; // Read mux value

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Whole block: bus slave, counter, compare, capture, flip-flop, irq
    always_comb begin
        next_s = s;
        wv = 32'h0000_0000;
        rd = 32'h0000_0000;

        // Write channel: address and data taken in either order
        if (s_axi_awvalid && !s.aw_got) begin
            next_s.aw_got = 1'b1;
            next_s.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.w_got) begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        do_wr = s.aw_got && s.w_got && !s.bvalid;
        if (do_wr) begin
            next_s.bvalid = 1'b1;
            next_s.bresp = tcp_mapped(s.waddr) ? tcp_pkg::RESP_OKAY : tcp_pkg::RESP_SLVERR;
        end
        // Slots reopen only once the response is taken
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
        end

        // Prescaler runs only while its run bit is set
        pmask = tcp_pkg::PRE_MASK32;
        case (s.mode[1:0])
            tcp_pkg::CLK_DIV2: pmask = tcp_pkg::PRE_MASK2;
            tcp_pkg::CLK_DIV8: pmask = tcp_pkg::PRE_MASK8;
            default: pmask = tcp_pkg::PRE_MASK32;
        endcase
        if (s.run[tcp_pkg::RUN_PRE]) begin
            next_s.pre = s.pre + 8'h01;
        end else begin
            next_s.pre = 8'h00;
        end
        tick = s.run[tcp_pkg::RUN_PRE] && ((s.pre & pmask) == pmask);

        // Trigger edges from the pin, one cycle of history
        next_s.trig_prev = trigger_count_input;
        rise = trigger_count_input && !s.trig_prev;
        fall = !trigger_count_input && s.trig_prev;

        // Clock source: pin edges, or a prescaler tap; pin counting still
        // needs the prescaler bit, software keeps it set
        if (s.mode[1:0] == tcp_pkg::CLK_EXT) begin
            cnt_en = s.run[tcp_pkg::RUN_CNT] && s.run[tcp_pkg::RUN_PRE] && rise;
        end else begin
            cnt_en = s.run[tcp_pkg::RUN_CNT] && tick;
        end

        // Counter wraps at 16 bits unless clear-on-match is set
        if (s.mode[tcp_pkg::MODE_CLR] && (s.count == s.cmp1)) begin
            cnt_nx = 16'h0000;
        end else begin
            cnt_nx = s.count + 16'h0001;
        end
        m0 = cnt_en && (cnt_nx == s.cmp0);
        m1 = cnt_en && (cnt_nx == s.cmp1);
        if (cnt_en) begin
            next_s.count = cnt_nx;
        end

        // Duty buffer lands with the period match
        if (m1 && s.run[tcp_pkg::RUN_DBUF]) begin
            next_s.cmp0 = s.cmp0_buf;
        end

        // Hardware captures; capture mode 00 blocks the pin
        cap0_ld = (s.mode[4:3] != tcp_pkg::CPM_OFF) && rise;
        if (cap0_ld) begin
            next_s.cap0 = s.count;
        end
        if ((s.mode[4:3] == tcp_pkg::CPM_RISE_FALL) && fall) begin
            next_s.cap1 = s.count;
        end
        // Trigger interrupt moves to the falling edge in mode 10
        if (s.mode[4:3] == tcp_pkg::CPM_RISE_FALL) begin
            trig_ev = fall;
        end else begin
            trig_ev = rise;
        end

        // Toggle flip-flop; several sources in one cycle toggle once each
        if ((m0 && s.ffcr[tcp_pkg::FF_T0]) ^ (m1 && s.ffcr[tcp_pkg::FF_T1])
            ^ (cap0_ld && s.ffcr[tcp_pkg::FF_TCAP])) begin
            next_s.toggle_ff = !s.toggle_ff;
        end

        // Register writes
        if (do_wr) begin
            case (s.waddr)
                tcp_pkg::OFS_RUN: begin
                    wv = tcp_merge({24'h0, s.run}, s.wdata, s.wstrb);
                    next_s.run = wv[7:0];
                end
                tcp_pkg::OFS_MODE: begin
                    wv = tcp_merge({24'h0, s.mode}, s.wdata, s.wstrb);
                    next_s.mode = wv[7:0] & ~(8'h01 << tcp_pkg::MODE_SWCAP);
                    if (wv[tcp_pkg::MODE_SWCAP]) begin
                        next_s.cap0 = s.count;
                    end
                end
                tcp_pkg::OFS_FFCR: begin
                    wv = tcp_merge({24'h0, s.ffcr}, s.wdata, s.wstrb);
                    next_s.ffcr = wv[7:0] & ~(8'h01 << tcp_pkg::FF_CLEAR);
                    if (wv[tcp_pkg::FF_CLEAR]) begin
                        next_s.toggle_ff = 1'b0;
                    end
                end
                tcp_pkg::OFS_IRQEN: begin
                    wv = tcp_merge({24'h0, s.irqen}, s.wdata, s.wstrb);
                    next_s.irqen = wv[7:0] & 8'h77;
                end
                tcp_pkg::OFS_CMP0: begin
                    wv = tcp_merge({16'h0, s.cmp0_buf}, s.wdata, s.wstrb);
                    next_s.cmp0_buf = wv[15:0];
                    // Unbuffered: the value takes effect at once
                    if (!s.run[tcp_pkg::RUN_DBUF]) begin
                        next_s.cmp0 = wv[15:0];
                    end
                end
                tcp_pkg::OFS_CMP1: begin
                    wv = tcp_merge({16'h0, s.cmp1}, s.wdata, s.wstrb);
                    next_s.cmp1 = wv[15:0];
                end
                tcp_pkg::OFS_MASK: begin
                    wv = tcp_merge({29'h0, s.mask}, s.wdata, s.wstrb);
                    next_s.mask = wv[2:0];
                end
                tcp_pkg::OFS_STATUS: begin
                    wv = tcp_merge(32'h0, s.wdata, s.wstrb);
                end
                default: begin
                    wv = 32'h0000_0000;
                end
            endcase
        end

        // Sticky status; a set in the clearing cycle survives
        ev = 3'h0;
        ev[tcp_pkg::ST_C0] = m0;
        ev[tcp_pkg::ST_C1] = m1;
        ev[tcp_pkg::ST_TRIG] = trig_ev;
        if (do_wr && (s.waddr == tcp_pkg::OFS_STATUS)) begin
            next_s.status = (s.status & ~wv[2:0]) | ev;
        end else begin
            next_s.status = s.status | ev;
        end
        next_s.irq = |(next_s.status & next_s.mask);

        // Compare pulses gated by a nonzero priority field; trigger pulse ungated
        next_s.c0_irq = m0 && (s.irqen[tcp_pkg::IE_C0_LO +: 3] != 3'h0);
        next_s.c1_irq = m1 && (s.irqen[tcp_pkg::IE_C1_LO +: 3] != 3'h0);
        next_s.trig_irq = trig_ev;

        // Pin polarity chosen by software
        next_s.pin = next_s.toggle_ff ^ s.ffcr[tcp_pkg::FF_POL];

        // Read channel: one cycle from address to data
        case (s_axi_araddr)
            tcp_pkg::OFS_RUN: rd = {24'h0, s.run};
            tcp_pkg::OFS_MODE: rd = {24'h0, s.mode};
            tcp_pkg::OFS_FFCR: rd = {24'h0, s.ffcr};
            tcp_pkg::OFS_IRQEN: rd = {24'h0, s.irqen};
            tcp_pkg::OFS_CMP0: rd = {16'h0, s.cmp0};
            tcp_pkg::OFS_CMP1: rd = {16'h0, s.cmp1};
            tcp_pkg::OFS_CAP0: rd = {16'h0, s.cap0};
            tcp_pkg::OFS_CAP1: rd = {16'h0, s.cap1};
            tcp_pkg::OFS_COUNT: rd = {16'h0, s.count};
            tcp_pkg::OFS_STATUS: rd = {29'h0, s.status};
            tcp_pkg::OFS_MASK: rd = {29'h0, s.mask};
            default: rd = 32'h0000_0000;
        endcase
        if (s_axi_arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd;
            next_s.rresp = tcp_mapped(s_axi_araddr) ? tcp_pkg::RESP_OKAY : tcp_pkg::RESP_SLVERR;
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // Synchronous reset to a stopped, cleared timer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops

    assign s_axi_awready = !s.aw_got;
    assign s_axi_wready = !s.w_got;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign pulse_output_pin = s.pin;
    assign compare0_irq = s.c0_irq;
    assign compare1_irq = s.c1_irq;
    assign trigger_ext_irq = s.trig_irq;
    assign irq = s.irq;

endmodule // tcp_timer16
`default_nettype wire

// ---- tb/tcp_chk_props.sv ----
/*
 Checker of the timer's bus handshakes and event pulses.
 Assumes a bind onto tcp_timer16 with its single clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tcp_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trigger_count_input,
    input wire logic compare0_irq,
    input wire logic compare1_irq,
    input wire logic trigger_ext_irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////
    // Both write halves taken at one edge
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Read address taken
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    ////////////////////////////////////////////////////////////////
    AST_WR_ANSWER: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid)
        else $error("read data missing");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write slot open while busy");
    AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read slot open while busy");
    // Match pulses last one cycle, the counter never matches twice in a row
    AST_C1_PULSE: assert property (compare1_irq |=> !compare1_irq)
        else $error("compare one pulse too long");
    AST_C0_PULSE: assert property (compare0_irq |=> !compare0_irq)
        else $error("compare zero pulse too long");
    // Trigger pulse only one cycle after a sampled pin change
    AST_TRIG_EDGE: assert property (trigger_ext_irq |-> $past(trigger_count_input) != $past(trigger_count_input, 2))
        else $error("trigger pulse without pin edge");
endmodule // tcp_chk
bind tcp_timer16 tcp_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .trigger_count_input(trigger_count_input),
    .compare0_irq(compare0_irq), .compare1_irq(compare1_irq), .trigger_ext_irq(trigger_ext_irq));
`default_nettype wire

// ---- tb/tcp_pin_model.sv ----
/*
 Pin partner: drives the count / trigger input, counts output edges.
 Assumes the bench clock; idle pin level is low.
*/
`timescale 1ns/1ps
`default_nettype none
module tcp_pin_model (
    input wire logic aclk,
    input wire logic pulse_output_pin,
    output logic trig_pin
);
    int tgl = 0; // Output edges seen
    logic last_out = 1'b0; // Previous output sample
    initial trig_pin = 1'b0;
    // Edge counter on the pulse output
    always @(posedge aclk) begin
        if (pulse_output_pin !== last_out) tgl++;
        last_out = pulse_output_pin;
    end
    // Pulse train; levels held several cycles so each edge is seen
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge aclk);
            trig_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            trig_pin <= 1'b0;
        end
        repeat (4) @(posedge aclk);
    endtask
endmodule // tcp_pin_model
`default_nettype wire

// ---- tb/tcp_timer16_tb.sv ----
/*
 Bench of the capture timer: bus tasks and directed sequences.
 Assumes the pin model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tcp_timer16_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pin, pout, c0i, c1i, tei, irq;
    logic [1:0] bresp, rresp, rr;
    logic [31:0] rdata, v;
    int num_errors = 0;
    int total_checks = 0;
    int c0n, c1n, tn, thi, hin, h1, n; // Event tallies
    tcp_timer16 dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trigger_count_input(pin),
        .pulse_output_pin(pout), .compare0_irq(c0i), .compare1_irq(c1i), .trigger_ext_irq(tei), .irq(irq));
    tcp_pin_model pm (.aclk(aclk), .pulse_output_pin(pout), .trig_pin(pin));
    ////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    initial begin
        forever #50 aclk = ~aclk;
    end
    // Tally pulses and high cycles as sampled at each edge
    always @(posedge aclk) begin
        if (c0i === 1'b1) c0n++;
        if (c1i === 1'b1) c1n++;
        if (tei === 1'b1) begin
            tn++;
            if (pin) thi++;
        end
        if (pout === 1'b1) hin++;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One write; both halves offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = tcp_pkg::RESP_OKAY);
        int k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 100);
        if (k >= 100) num_errors++;
        bready <= 1'b0;
        chk(bresp, er);
    endtask
    // One read; data and response taken at the handshake edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 100);
        if (k >= 100) num_errors++;
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = tcp_pkg::RESP_OKAY);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e);
        chk(r, er);
    endtask
    // Cycles until the next compare-1 pulse, bounded
    task automatic wc1();
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (c1i !== 1'b1 && n < 200);
        if (c1i !== 1'b1) num_errors++;
    endtask
    // Fixed observation window over whole output periods; tallies
    // zeroed and read off the edge so no tally races the clear
    task automatic win();
        @(negedge aclk);
        hin = 0;
        pm.tgl = 0;
        c0n = 0;
        c1n = 0;
        repeat (48) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic conclude();
        if (num_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset state and unmapped places
        rdc(tcp_pkg::OFS_RUN, 32'h0);
        rdc(tcp_pkg::OFS_COUNT, 32'h0);
        chk({irq, awready}, 2'h1);
        wr(8'h2c, 32'h1, tcp_pkg::RESP_SLVERR);
        rdc(8'h30, 32'h0, tcp_pkg::RESP_SLVERR);
        rdc(8'h02, 32'h0, tcp_pkg::RESP_SLVERR);
        wr(tcp_pkg::OFS_IRQEN, 32'hff);
        rdc(tcp_pkg::OFS_IRQEN, 32'h77);
        // Interval of six /2 steps with clear on compare 1
        wr(tcp_pkg::OFS_MODE, 32'h21);
        wr(tcp_pkg::OFS_CMP1, 32'h5);
        wr(tcp_pkg::OFS_IRQEN, 32'h40);
        wr(tcp_pkg::OFS_RUN, 32'h05);
        wc1();
        wc1();
        chk(n, 12);
        // Interrupt raised, masked, cleared
        wr(tcp_pkg::OFS_MASK, 32'h2);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b1);
        wr(tcp_pkg::OFS_MASK, 32'h0);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        wr(tcp_pkg::OFS_RUN, 32'h0);
        wr(tcp_pkg::OFS_STATUS, 32'h7);
        rdc(tcp_pkg::OFS_STATUS, 32'h0);
        // Pulse generation; first match decides the phase
        rd(tcp_pkg::OFS_COUNT, v, rr);
        wr(tcp_pkg::OFS_IRQEN, 32'h4);
        wr(tcp_pkg::OFS_CMP0, 32'h1);
        wr(tcp_pkg::OFS_FFCR, 32'h0d);
        wr(tcp_pkg::OFS_RUN, 32'h05);
        repeat (24) @(posedge aclk);
        win();
        h1 = hin;
        chk(pm.tgl, 8);
        chk(h1, (v == 0 || v == 5) ? 32 : 16);
        chk(c1n, 0);
        chk(c0n, 4);
        wr(tcp_pkg::OFS_FFCR, 32'h0e);
        repeat (4) @(posedge aclk);
        win();
        chk(hin, 48 - h1);
        // Buffered compare 0 moves only at compare-1 match
        wr(tcp_pkg::OFS_RUN, 32'h84);
        wr(tcp_pkg::OFS_CMP0, 32'h3);
        rdc(tcp_pkg::OFS_CMP0, 32'h1);
        wr(tcp_pkg::OFS_IRQEN, 32'h40);
        wr(tcp_pkg::OFS_RUN, 32'h85);
        wc1();
        rdc(tcp_pkg::OFS_CMP0, 32'h3);
        wr(tcp_pkg::OFS_RUN, 32'h0);
        wr(tcp_pkg::OFS_FFCR, 32'h1);
        repeat (2) @(posedge aclk);
        chk(pout, 1'b0);
        // Software capture, then counting pin edges
        rd(tcp_pkg::OFS_COUNT, v, rr);
        wr(tcp_pkg::OFS_MODE, 32'h40);
        rdc(tcp_pkg::OFS_CAP0, v);
        wr(tcp_pkg::OFS_MODE, 32'h0);
        wr(tcp_pkg::OFS_RUN, 32'h05);
        tn = 0;
        thi = 0;
        pm.pulses(7);
        rdc(tcp_pkg::OFS_COUNT, (v + 7) & 32'hffff);
        chk(tn, 7);
        chk(thi, 7);
        // Rise and fall captures with toggle on capture
        wr(tcp_pkg::OFS_RUN, 32'h0);
        wr(tcp_pkg::OFS_MODE, 32'h10);
        wr(tcp_pkg::OFS_FFCR, 32'h11);
        tn = 0;
        thi = 0;
        pm.pulses(1);
        rdc(tcp_pkg::OFS_CAP0, (v + 7) & 32'hffff);
        rdc(tcp_pkg::OFS_CAP1, (v + 7) & 32'hffff);
        chk({tn[1:0], thi[1:0]}, 4'h4);
        chk(pout, 1'b1);
        conclude();
    end
endmodule // tcp_timer16_tb
`default_nettype wire
